// ### common/sevc_pkg.sv
package sevc_pkg;
  // seven bcd digits
  localparam int unsigned SEVC_DIGITS = 7;
  localparam int unsigned SEVC_CNT_W = 4 * SEVC_DIGITS;
  localparam logic [27:0] SEVC_CNT_MAX = 28'h9999999;
  localparam logic [27:0] SEVC_CNT_RST = 28'h0000000;
  // debounce settling time
  localparam int unsigned SEVC_CLK_MHZ = 100;
  localparam int unsigned SEVC_DEBOUNCE_US = 10000;
  localparam int unsigned SEVC_DEBOUNCE_CYC = SEVC_DEBOUNCE_US * SEVC_CLK_MHZ;
  localparam int unsigned SEVC_RATE_W = 32;
endpackage

// ### common/sevc_flt_if.sv
`timescale 1ns/1ns
interface sevc_flt_if;
  logic raw;
  logic level;
  logic rise;
  modport filt (input raw, output level, output rise);
  modport user (output raw, input level, input rise);
endinterface

// ### rtl/sevc_debounce.sv
`timescale 1ns/1ns
module sevc_debounce
  import sevc_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = SEVC_DEBOUNCE_CYC
) (
  // clock, reset and enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // filter link
  sevc_flt_if.filt flt
);
  logic [31:0] cnt_q, cnt_d;
  logic level_q, level_d;
  logic rise_q, rise_d;

  // level accepted only after the raw input differs for a whole settle time
  always_comb begin
    cnt_d = 32'h0;
    level_d = level_q;
    rise_d = 1'b0;
    if (flt.raw != level_q) begin
      if (cnt_q >= SETTLE_CYC - 1) begin
        level_d = flt.raw;
        rise_d = flt.raw;
      end else begin
        cnt_d = cnt_q + 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= 32'h0;
      level_q <= 1'b0;
      rise_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      level_q <= level_d;
      rise_q <= rise_d;
    end
  end

  assign flt.level = level_q;
  assign flt.rise = rise_q;

  a_settle_before_rise: assert property (@(posedge clk) disable iff (!rstn)
    rise_q |-> level_q)
    else $error("rise pulse without accepted high level");
  a_rise_on_level: assert property (@(posedge clk) disable iff (!rstn)
    $rose(level_q) |-> rise_q)
    else $error("accepted high level without a rise pulse");
endmodule

// ### rtl/sevc_counter.sv
`timescale 1ns/1ns
// What this block does
// - count events on the tally input pin
// - saturate at 9,999,999, then hold
// - count query returns count, leaves it
// - clear command zeroes the count
// - fetch-and-zero atomic, keeps simultaneous event
// - count zero after power-up reset
// - restart and line break leave count
// - debounce the event input
// - read-data returns rate, not total
module sevc_counter
  import sevc_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = SEVC_DEBOUNCE_CYC,
  parameter int unsigned RATE_W = SEVC_RATE_W,
  // saturation point; a bench may lower it so the limit is reachable in a short run
  parameter logic [SEVC_CNT_W-1:0] CNT_MAX = SEVC_CNT_MAX
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // event pin
  input wire logic tally_input_pin,
  // host commands, one-cycle pulses from the command decoder
  input wire logic count_query_cmd,
  input wire logic clear_cmd,
  input wire logic fetch_and_zero_cmd,
  input wire logic read_data_cmd,
  input wire logic module_restart_cmd,
  input wire logic line_break,
  // measured rate from the frequency path
  input wire logic [RATE_W-1:0] rate_value,
  // answers
  output logic [SEVC_CNT_W-1:0] count_out,
  output logic count_valid,
  output logic [RATE_W-1:0] rate_out,
  output logic rate_valid,
  output logic saturated
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser and filter
  logic sync1_q, sync2_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else if (ce) begin
      sync1_q <= tally_input_pin;
      sync2_q <= sync1_q;
    end
  end

  sevc_flt_if flt ();
  assign flt.raw = sync2_q;

  sevc_debounce #(
    .SETTLE_CYC(SETTLE_CYC)
  ) u_deb (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .flt(flt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bcd counter
  logic [SEVC_CNT_W-1:0] cnt_q, cnt_d, inc;
  logic [SEVC_DIGITS:0] carry;

  // ripple bcd increment, one digit per generate step
  assign carry[0] = 1'b1;
  for (genvar g = 0; g < SEVC_DIGITS; g++) begin : g_dig
    logic [3:0] dig;
    assign dig = cnt_q[4*g +: 4];
    assign inc[4*g +: 4] = !carry[g] ? dig : (dig == 4'h9) ? 4'h0 : dig + 4'h1;
    assign carry[g+1] = carry[g] && (dig == 4'h9);
    a_bcd_digits: assert property (@(posedge clk) disable iff (!rstn)
      dig <= 4'h9)
      else $error("count digit out of bcd range");
  end

  logic at_max;
  assign at_max = (cnt_q == CNT_MAX);

  logic [SEVC_CNT_W-1:0] cnt_out_q, cnt_out_d;
  logic cnt_vld_q, cnt_vld_d;
  logic [RATE_W-1:0] rate_q, rate_d;
  logic rate_vld_q, rate_vld_d;
  logic sat_q, sat_d;

  // restart and line break are deliberately not inputs to this logic
  always_comb begin
    cnt_d = cnt_q;
    cnt_out_d = cnt_out_q;
    cnt_vld_d = 1'b0;
    rate_d = rate_q;
    rate_vld_d = 1'b0;
    if (count_query_cmd || fetch_and_zero_cmd) begin
      cnt_out_d = cnt_q;
      cnt_vld_d = 1'b1;
    end
    if (clear_cmd || fetch_and_zero_cmd) begin
      // an edge in the same cycle starts the new count at one
      cnt_d = flt.rise ? {{(SEVC_CNT_W-1){1'b0}}, 1'b1} : SEVC_CNT_RST;
    end else if (flt.rise && !at_max) begin
      cnt_d = inc;
    end
    if (read_data_cmd) begin
      rate_d = rate_value;
      rate_vld_d = 1'b1;
    end
    sat_d = (cnt_d == CNT_MAX);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= SEVC_CNT_RST;
      cnt_out_q <= SEVC_CNT_RST;
      cnt_vld_q <= 1'b0;
      rate_q <= '0;
      rate_vld_q <= 1'b0;
      sat_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      cnt_out_q <= cnt_out_d;
      cnt_vld_q <= cnt_vld_d;
      rate_q <= rate_d;
      rate_vld_q <= rate_vld_d;
      sat_q <= sat_d;
    end
  end

  assign count_out = cnt_out_q;
  assign count_valid = cnt_vld_q;
  assign rate_out = rate_q;
  assign rate_valid = rate_vld_q;
  assign saturated = sat_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_sat_holds: assert property (@(posedge clk) disable iff (!rstn)
    ce && at_max && !clear_cmd && !fetch_and_zero_cmd |=> at_max)
    else $error("count left maximum without a clear");

  a_edge_at_max: assert property (@(posedge clk) disable iff (!rstn)
    ce && at_max && flt.rise && !clear_cmd && !fetch_and_zero_cmd |=> $stable(cnt_q))
    else $error("edge moved a saturated count");

  a_sat_flag: assert property (@(posedge clk) disable iff (!rstn)
    saturated == at_max)
    else $error("saturated flag disagrees with count");

  a_query_no_change: assert property (@(posedge clk) disable iff (!rstn)
    ce && count_query_cmd && !clear_cmd && !fetch_and_zero_cmd && !flt.rise
    |=> $stable(cnt_q) && cnt_out_q == $past(cnt_q))
    else $error("query changed count or answered wrong");

  a_answer_pulse: assert property (@(posedge clk) disable iff (!rstn)
    ce && !count_query_cmd && !fetch_and_zero_cmd |=> !cnt_vld_q)
    else $error("count answer without a request");

  a_answer_holds: assert property (@(posedge clk) disable iff (!rstn)
    ce && !count_query_cmd && !fetch_and_zero_cmd |=> $stable(cnt_out_q))
    else $error("count answer changed without a request");

  a_clear_zero: assert property (@(posedge clk) disable iff (!rstn)
    ce && clear_cmd && !flt.rise |=> cnt_q == SEVC_CNT_RST)
    else $error("clear did not zero count");

  a_fetch_keeps_edge: assert property (@(posedge clk) disable iff (!rstn)
    ce && fetch_and_zero_cmd && flt.rise
    |=> cnt_q == 28'h0000001 && cnt_out_q == $past(cnt_q) && cnt_vld_q)
    else $error("fetch and zero lost an event");

  a_fetch_zero: assert property (@(posedge clk) disable iff (!rstn)
    ce && fetch_and_zero_cmd && !flt.rise
    |=> cnt_q == SEVC_CNT_RST && cnt_out_q == $past(cnt_q) && cnt_vld_q)
    else $error("fetch and zero answered wrong or left a count");

  a_one_per_edge: assert property (@(posedge clk) disable iff (!rstn)
    ce && flt.rise && !at_max && !clear_cmd && !fetch_and_zero_cmd
    |=> cnt_q == $past(inc) && cnt_q != $past(cnt_q))
    else $error("edge did not advance count by one");

  a_no_edge_stable: assert property (@(posedge clk) disable iff (!rstn)
    ce && !flt.rise && !clear_cmd && !fetch_and_zero_cmd |=> $stable(cnt_q))
    else $error("count moved without an edge or clear");

  a_restart_inert: assert property (@(posedge clk) disable iff (!rstn)
    ce && (module_restart_cmd || line_break) && !flt.rise && !clear_cmd
    && !fetch_and_zero_cmd |=> $stable(cnt_q))
    else $error("restart or line break moved the count");

  // a frozen enable must not let a held rise pulse count twice
  a_frozen_count: assert property (@(posedge clk) disable iff (!rstn)
    !ce |=> $stable(cnt_q) && $stable(cnt_out_q))
    else $error("count moved while the clock enable was low");

  a_pin_sync: assert property (@(posedge clk) disable iff (!rstn)
    ce |=> sync1_q == $past(tally_input_pin) && sync2_q == $past(sync1_q))
    else $error("synchroniser stage skipped");

  a_carry_at_max: assert property (@(posedge clk) disable iff (!rstn)
    carry[SEVC_DIGITS] == (cnt_q == SEVC_CNT_MAX))
    else $error("ripple carry disagrees with all-nines count");

  a_rate_answer: assert property (@(posedge clk) disable iff (!rstn)
    ce && read_data_cmd |=> rate_valid && rate_out == $past(rate_value))
    else $error("read data answer wrong");

  a_rate_steady: assert property (@(posedge clk) disable iff (!rstn)
    ce && !read_data_cmd |=> $stable(rate_q) && !rate_vld_q)
    else $error("rate answer changed without a request");

  a_rate_leaves_count: assert property (@(posedge clk) disable iff (!rstn)
    ce && read_data_cmd && !flt.rise && !clear_cmd && !fetch_and_zero_cmd
    |=> $stable(cnt_q))
    else $error("read data disturbed the event total");

  a_reset_zero: assert property (@(posedge clk)
    !rstn |=> cnt_q == SEVC_CNT_RST)
    else $error("count not zero after reset");
endmodule

// ### verification/sevc_host_model.sv
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// host side of the command link: one-cycle request pulses, one bit per command
// bit0 query, bit1 clear, bit2 fetch-and-zero, bit3 read rate, bit4 restart, bit5 break
module sevc_host_model (
  // clock
  input wire logic clk,
  // command pulses
  output logic [5:0] cmd
);
  initial cmd = 6'h00;
  // send drives one command word for one clock cycle, then returns cmd to zero
  task automatic send(input logic [5:0] c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= 6'h00;
  endtask
endmodule

// ### verification/tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] %0t value %h expected %h", $time, a, b); end end
module tb_top;
  import sevc_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic pin = 1'b0;
  logic ce = 1'b1;
  // low saturation point lets the limit be reached in a short run
  localparam logic [27:0] SAT_MAX = 28'h0000020;
  logic [5:0] cmd;
  logic [31:0] rate_in = 32'h1234abcd;
  logic [SEVC_CNT_W-1:0] count_out;
  logic [31:0] rate_out;
  logic count_valid;
  logic rate_valid;
  logic saturated;
  logic [27:0] v;
  int n_mismatch = 0;
  int checks_done = 0;
  initial forever #5 clk = ~clk;
  sevc_host_model u_host (.clk(clk), .cmd(cmd));
  // short settle time keeps each press about two dozen cycles
  sevc_counter #(.SETTLE_CYC(4), .CNT_MAX(SAT_MAX)) u_dut (.clk(clk), .rstn(rstn), .ce(ce),
    .tally_input_pin(pin), .count_query_cmd(cmd[0]), .clear_cmd(cmd[1]),
    .fetch_and_zero_cmd(cmd[2]), .read_data_cmd(cmd[3]), .module_restart_cmd(cmd[4]),
    .line_break(cmd[5]), .rate_value(rate_in), .count_out(count_out),
    .count_valid(count_valid), .rate_out(rate_out), .rate_valid(rate_valid),
    .saturated(saturated));
  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic ask(input logic [5:0] c, output logic [27:0] r);
    int i;
    u_host.send(c);
    for (i = 0; i < 4; i++) begin
      #1;
      if (count_valid === 1'b1 || rate_valid === 1'b1) break;
      @(posedge clk);
    end
    if (i == 4) begin
      n_mismatch++;
      conclude();
    end
    r = count_out;
  endtask
  // contact bounce: one one-cycle glitch, then a clean long press
  task automatic press();
    @(posedge clk) pin <= 1'b1;
    @(posedge clk) pin <= 1'b0;
    @(posedge clk) pin <= 1'b1;
    repeat (10) @(posedge clk);
    pin <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    ask(6'h01, v);
    `CHK(v, 28'h0000000)
  endtask
  task automatic t_count();
    repeat (12) press();
    ask(6'h01, v);
    `CHK(v, 28'h0000012)
    ask(6'h01, v);
    `CHK(v, 28'h0000012)
  endtask
  task automatic t_restart();
    u_host.send(6'h30);
    ask(6'h01, v);
    `CHK(v, 28'h0000012)
  endtask
  task automatic t_rate();
    ask(6'h08, v);
    `CHK(rate_out, 32'h1234abcd)
  endtask
  task automatic t_fetch();
    press();
    ask(6'h04, v);
    `CHK(v, 28'h0000013)
    ask(6'h01, v);
    `CHK(v, 28'h0000000)
  endtask
  task automatic t_clear();
    press();
    press();
    u_host.send(6'h02);
    ask(6'h01, v);
    `CHK(v, 28'h0000000)
    `CHK(saturated, 1'b0)
  endtask
  // pin activity and a query while frozen must leave no trace
  task automatic t_freeze();
    @(posedge clk) ce <= 1'b0;
    press();
    u_host.send(6'h01);
    #1;
    `CHK(count_valid, 1'b0)
    @(posedge clk) ce <= 1'b1;
    ask(6'h01, v);
    `CHK(v, 28'h0000012)
  endtask
  // fetch lands in the very cycle the filter reports a rise
  task automatic t_fetch_edge();
    press();
    @(posedge clk) pin <= 1'b1;
    repeat (5) @(posedge clk);
    ask(6'h04, v);
    `CHK(v, 28'h0000001)
    repeat (6) @(posedge clk);
    pin <= 1'b0;
    repeat (10) @(posedge clk);
    ask(6'h01, v);
    `CHK(v, 28'h0000001)
  endtask
  task automatic t_power();
    press();
    @(posedge clk) rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    ask(6'h01, v);
    `CHK(v, 28'h0000000)
  endtask
  task automatic t_sat();
    repeat (20) press();
    ask(6'h01, v);
    `CHK(v, SAT_MAX)
    `CHK(saturated, 1'b1)
    press();
    ask(6'h01, v);
    `CHK(v, SAT_MAX)
    u_host.send(6'h02);
    ask(6'h01, v);
    `CHK(v, 28'h0000000)
    `CHK(saturated, 1'b0)
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_count();
    t_freeze();
    t_restart();
    t_rate();
    t_fetch();
    t_fetch_edge();
    t_clear();
    t_power();
    t_sat();
    conclude();
  end
endmodule
